// *** prof_pkg.sv ***
// Package: control block layout, record layout, commands and states for the record inserter
package prof_pkg;
    // Control block byte offsets
    localparam logic [7:0] CB_FLAGS_OFF = 8'h00;
    localparam logic [7:0] CB_SIZE_OFF = 8'h04;
    localparam logic [7:0] CB_BASE_OFF = 8'h08;
    localparam logic [7:0] CB_PRODUCER_OFF = 8'h10;
    localparam logic [7:0] CB_DROPPED_OFF = 8'h18;
    localparam logic [7:0] CB_THRESH_OFF = 8'h20;
    localparam logic [7:0] CB_CONSUMER_OFF = 8'h40;
    localparam logic [7:0] CB_PERIOD1_OFF = 8'h80;
    // Flag bit positions in the control block flags word
    localparam int FLAG_VALUE_EVT_BIT = 1;
    localparam int FLAG_THRESH_INT_BIT = 31;
    // Record layout
    localparam int RECORD_BYTES = 32;
    localparam logic [7:0] TYPE_VALUE_SAMPLE = 8'h01;
    localparam logic [7:0] TYPE_USER_RECORD = 8'hFF;
    localparam logic [31:0] ZERO_32 = 32'h00000000;
    localparam logic [63:0] ZERO_64 = 64'h0000000000000000;
    localparam logic [31:0] ONE_32 = 32'h00000001;
    localparam logic [63:0] ONE_64 = 64'h0000000000000001;

    // Instruction request from the pipeline
    typedef struct packed {
        logic is_user;          // High: user record, low: value sample
        logic size_is_32;       // Operand size 32, zero extend extra register
        logic [63:0] extra_reg; // Register chosen by the extra register selector
        logic [31:0] operand;   // Second operand, register or memory
        logic [31:0] immediate; // Third operand, truncated to 16 bits
        logic [63:0] ip;        // Instruction address
    } insert_req_t;

    // One event record as written to the ring
    typedef struct packed {
        logic [63:0] secondary_payload; // Bytes 23..16
        logic [63:0] ip;                // Bytes 15..8
        logic [31:0] primary_payload;   // Bytes 7..4
        logic [15:0] flags;             // Bytes 3..2
        logic [7:0] rsvd;               // Byte 1
        logic [7:0] record_type_code;   // Byte 0
    } event_record_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_WRITE = 4'h2,
        ST_UPDATE = 4'h4,
        ST_DONE = 4'h8
    } ins_state_t;
endpackage

// *** profiling_record_inserter.sv ***
// Record inserter: executes value-sample and user-record instructions into the ring
`timescale 1ns/1ns

// Notes on behaviour
// [RQ1] Value sample decrements its counter; records only when result turns negative.
// [RQ2] No record due means no memory operand fetch.
// [RQ3] Value-sample records carry type code 1.
// [RQ4] Extra register goes to bytes 23..16, zero extended at size 32.
// [RQ5] Second operand goes to bytes 7..4.
// [RQ6] Immediate truncated to 16 bits into bytes 3..2.
// [RQ7] After a value record with room or continuous, advance and reload counter.
// [RQ8] Occupancy above threshold with interrupt enabled raises an interrupt.
// [RQ9] Continuous mode: advanced producer equal to consumer bumps dropped count.
// [RQ10] Synchronized and full: overwrite last record, bump dropped, hold producer.
// [RQ11] Value sample faults outside protected mode or facility unavailable.
// [RQ12] Value sample does nothing when disabled or its event is off.
// [RQ13] Value sample changes no general register or condition code.
// [RQ14] Every completed value sample counts as a retired instruction.
// [RQ15] User record writes unconditionally when enabled, type code 255.
// [RQ16] User record with room or continuous: advance producer, clear carry.
// [RQ17] User record synchronized and full: overwrite, bump dropped, hold, set carry.
// [RQ18] Disabled user record only clears carry.
// [RQ19] User record faults outside protected mode or facility unavailable.
// [RQ20] Completed user record counts as a retired instruction.
// [RQ21] Constant fields latched at enable; block access faults fault the instruction.
// [RQ22] Consumer offset lives at control block offset 64, first period at 128.
// [RQ23] Software keeps reserved control block fields at zero.
// [RQ24] Producer equal to consumer means the ring is empty.
// [RQ25] Counter reloads replace the configured low bits with random values.
module profiling_record_inserter #(
    parameter int RAND_BITS_MAX = 16
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Session configuration; flags, size, base, threshold, period and random bits latched while enable rises
    input wire logic enable_in,
    input wire logic available_in,
    input wire logic protected_mode_in,
    input wire logic continuous_mode_in,
    input wire logic [31:0] cb_flags_in,
    input wire logic [31:0] buffer_size_in,
    input wire logic [63:0] buffer_base_in,
    input wire logic [31:0] threshold_in,
    input wire logic [31:0] first_event_period_in,
    input wire logic [3:0] random_bits_in,
    input wire logic [31:0] ring_consumer_offset_in,
    // Instruction request and operand fetch
    input wire logic req_valid_in,
    input wire prof_pkg::insert_req_t req_in,
    input wire logic operand_ready_in,
    // Memory write port for records and control block fields
    input wire logic mem_ack_in,
    input wire logic mem_fault_in,
    output logic operand_fetch_out,
    output logic mem_wr_out,
    output logic [63:0] mem_addr_out,
    output prof_pkg::event_record_t mem_record_out,
    output logic mem_is_record_out,
    output logic [63:0] mem_field_out,
    output logic done_out,
    output logic invalid_opcode_fault_out,
    output logic access_fault_out,
    output logic carry_flag_out,
    output logic carry_valid_out,
    output logic retired_out,
    output logic threshold_int_out,
    output logic [31:0] ring_producer_offset_out,
    output logic [63:0] dropped_event_count_out
);

    prof_pkg::ins_state_t state_reg;
    prof_pkg::insert_req_t req_reg;
    logic enable_d_reg;
    logic [31:0] flags_reg;
    logic [31:0] size_reg;
    logic [63:0] base_reg;
    logic [31:0] thresh_reg;
    logic [31:0] period_reg;
    logic [3:0] rand_bits_reg;
    logic [31:0] counter_reg;
    logic [31:0] producer_reg;
    logic [63:0] dropped_reg;
    logic [15:0] lfsr_reg;
    logic [31:0] counter_next;
    logic [31:0] advanced;
    logic full;
    logic will_drop;
    logic [31:0] occupancy;
    logic [1:0] upd_step_reg;
    // Overwrite decision taken at the record write; the producer has moved by the time of done
    logic overwrote_reg;
    logic [63:0] cb_base_reg;

    // Wrap an offset one record forward inside the ring
    function automatic logic [31:0] next_offset(input logic [31:0] off, input logic [31:0] sz);
        logic [31:0] n;
        n = off + 32'(prof_pkg::RECORD_BYTES);
        next_offset = (n >= sz) ? prof_pkg::ZERO_32 : n;
    endfunction

    // Build a record; same layout for both instructions
    function automatic prof_pkg::event_record_t build(input prof_pkg::insert_req_t r);
        prof_pkg::event_record_t e;
        e.record_type_code = r.is_user ? prof_pkg::TYPE_USER_RECORD
                                       : prof_pkg::TYPE_VALUE_SAMPLE; // [RQ3] [RQ15]
        e.rsvd = 8'h00;
        e.flags = r.immediate[15:0]; // [RQ6]
        e.primary_payload = r.operand; // [RQ5]
        e.ip = r.ip;
        e.secondary_payload = r.size_is_32 ? {32'h00000000, r.extra_reg[31:0]}
                                           : r.extra_reg; // [RQ4]
        build = e;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Ring bookkeeping, combinational
    always_comb begin
        counter_next = counter_reg - prof_pkg::ONE_32; // [RQ1]
        advanced = next_offset(producer_reg, size_reg);
        full = (advanced == ring_consumer_offset_in); // [RQ24] [RQ22]
        will_drop = full && !continuous_mode_in;
        occupancy = (producer_reg >= ring_consumer_offset_in)
                  ? producer_reg - ring_consumer_offset_in
                  : size_reg - ring_consumer_offset_in + producer_reg;
    end

    // Constant fields latched on the enable edge; reset keeps session empty
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            enable_d_reg <= 1'b0;
            flags_reg <= prof_pkg::ZERO_32;
            size_reg <= prof_pkg::ZERO_32;
            base_reg <= prof_pkg::ZERO_64;
            thresh_reg <= prof_pkg::ZERO_32;
            period_reg <= prof_pkg::ZERO_32;
            rand_bits_reg <= 4'h0;
        end else begin
            enable_d_reg <= enable_in;
            if (enable_in && !enable_d_reg) begin // [RQ21]
                flags_reg <= cb_flags_in;
                size_reg <= buffer_size_in;
                base_reg <= buffer_base_in;
                thresh_reg <= threshold_in;
                period_reg <= first_event_period_in;
                rand_bits_reg <= random_bits_in;
            end
        end
    end

    // Free running pseudo-random source for counter reloads
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lfsr_reg <= 16'hACE1;
        end else begin
            lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Instruction sequencer
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= prof_pkg::ST_IDLE;
            req_reg <= '0;
            counter_reg <= prof_pkg::ZERO_32;
            producer_reg <= prof_pkg::ZERO_32;
            dropped_reg <= prof_pkg::ZERO_64;
            upd_step_reg <= 2'h0;
            overwrote_reg <= 1'b0;
            operand_fetch_out <= 1'b0;
            mem_wr_out <= 1'b0;
            mem_addr_out <= prof_pkg::ZERO_64;
            mem_record_out <= '0;
            mem_is_record_out <= 1'b0;
            mem_field_out <= prof_pkg::ZERO_64;
            done_out <= 1'b0;
            invalid_opcode_fault_out <= 1'b0;
            access_fault_out <= 1'b0;
            carry_flag_out <= 1'b0;
            carry_valid_out <= 1'b0;
            retired_out <= 1'b0;
            threshold_int_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            invalid_opcode_fault_out <= 1'b0;
            access_fault_out <= 1'b0;
            carry_valid_out <= 1'b0;
            retired_out <= 1'b0;
            threshold_int_out <= 1'b0;
            if (enable_in && !enable_d_reg) begin
                producer_reg <= prof_pkg::ZERO_32;
                counter_reg <= first_event_period_in;
            end
            unique case (state_reg)
                prof_pkg::ST_IDLE: begin
                    if (req_valid_in) begin
                        req_reg <= req_in;
                        if (!protected_mode_in || !available_in) begin
                            invalid_opcode_fault_out <= 1'b1; // [RQ11] [RQ19]
                        end else if (!enable_in) begin
                            // Disabled: value sample is a no-op, user record clears carry
                            done_out <= 1'b1; // [RQ12]
                            retired_out <= 1'b1;
                            carry_valid_out <= req_in.is_user; // [RQ18]
                            carry_flag_out <= 1'b0;
                        end else if (!req_in.is_user && !flags_reg[prof_pkg::FLAG_VALUE_EVT_BIT])
                        begin
                            done_out <= 1'b1; // [RQ12]
                            retired_out <= 1'b1; // [RQ14]
                        end else if (!req_in.is_user && !counter_next[31]) begin
                            // No record due: operand never fetched
                            counter_reg <= counter_next; // [RQ1] [RQ2]
                            done_out <= 1'b1;
                            retired_out <= 1'b1; // [RQ14]
                        end else begin
                            if (!req_in.is_user) begin
                                counter_reg <= counter_next;
                            end
                            operand_fetch_out <= 1'b1;
                            state_reg <= prof_pkg::ST_WRITE;
                        end
                    end
                end
                prof_pkg::ST_WRITE: begin
                    // Wait for the operand, then write the record at the producer slot
                    if (operand_fetch_out && operand_ready_in) begin
                        operand_fetch_out <= 1'b0;
                        mem_wr_out <= 1'b1;
                        mem_is_record_out <= 1'b1;
                        mem_addr_out <= base_reg + {32'h00000000, producer_reg};
                        mem_record_out <= build(req_in);
                        req_reg.operand <= req_in.operand;
                    end else if (mem_wr_out && mem_ack_in) begin
                        mem_wr_out <= 1'b0;
                        mem_is_record_out <= 1'b0;
                        if (mem_fault_in) begin
                            access_fault_out <= 1'b1; // [RQ21]
                            state_reg <= prof_pkg::ST_IDLE;
                        end else begin
                            // Full in synchronized mode: slot reused next time
                            if (!will_drop) begin
                                producer_reg <= advanced; // [RQ7] [RQ16]
                                if (!req_reg.is_user) begin
                                    counter_reg <= (period_reg & ~rand_mask(rand_bits_reg))
                                        | ({16'h0000, lfsr_reg} & rand_mask(rand_bits_reg));
                                end
                            end
                            if (full) begin
                                dropped_reg <= dropped_reg + prof_pkg::ONE_64; // [RQ9] [RQ10]
                            end
                            overwrote_reg <= will_drop; // [RQ17]
                            upd_step_reg <= 2'h0;
                            state_reg <= prof_pkg::ST_UPDATE;
                        end
                    end
                end
                prof_pkg::ST_UPDATE: begin
                    // Publish producer offset then dropped count to the control block
                    if (!mem_wr_out) begin
                        mem_wr_out <= 1'b1;
                        mem_addr_out <= base_cb_addr(upd_step_reg);
                        mem_field_out <= (upd_step_reg == 2'h0) ? {32'h00000000, producer_reg}
                                                                 : dropped_reg;
                    end else if (mem_ack_in) begin
                        mem_wr_out <= 1'b0;
                        if (mem_fault_in) begin
                            access_fault_out <= 1'b1; // [RQ21]
                            state_reg <= prof_pkg::ST_IDLE;
                        end else if (upd_step_reg == 2'h1) begin
                            state_reg <= prof_pkg::ST_DONE;
                        end else begin
                            upd_step_reg <= 2'h1;
                        end
                    end
                end
                prof_pkg::ST_DONE: begin
                    done_out <= 1'b1;
                    retired_out <= 1'b1; // [RQ14] [RQ20]
                    // Only the user record reports through carry; value sample leaves flags
                    carry_valid_out <= req_reg.is_user; // [RQ13]
                    carry_flag_out <= req_reg.is_user && overwrote_reg; // [RQ16] [RQ17]
                    threshold_int_out <= flags_reg[prof_pkg::FLAG_THRESH_INT_BIT]
                                         && (occupancy > thresh_reg); // [RQ8]
                    state_reg <= prof_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Low-bit mask for counter randomisation
    function automatic logic [31:0] rand_mask(input logic [3:0] n);
        rand_mask = (prof_pkg::ONE_32 << n) - prof_pkg::ONE_32; // [RQ25]
    endfunction

    // Control block field address; control block assumed to start 128 bytes below the buffer base latched at enable
    function automatic logic [63:0] base_cb_addr(input logic [1:0] step);
        base_cb_addr = cb_base_reg + {56'h00000000000000,
            (step == 2'h0) ? prof_pkg::CB_PRODUCER_OFF : prof_pkg::CB_DROPPED_OFF};
    endfunction
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cb_base_reg <= prof_pkg::ZERO_64;
        end else if (enable_in && !enable_d_reg) begin
            cb_base_reg <= buffer_base_in - {56'h00000000000000, prof_pkg::CB_PERIOD1_OFF};
        end
    end

    // Output mirrors of internal state
    assign ring_producer_offset_out = producer_reg;
    assign dropped_event_count_out = dropped_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sample_quiet_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_reg == prof_pkg::ST_IDLE && req_valid_in && !req_in.is_user && enable_in
         && protected_mode_in && available_in && flags_reg[prof_pkg::FLAG_VALUE_EVT_BIT]
         && !counter_next[31]) |=> !operand_fetch_out && done_out) // [RQ2]
        else $error("Value sample fetched operand with no record due");
    fault_gate_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_reg == prof_pkg::ST_IDLE && req_valid_in && !protected_mode_in)
        |=> invalid_opcode_fault_out && !done_out) // [RQ11] [RQ19]
        else $error("Missing invalid opcode fault");
    hold_full_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_reg == prof_pkg::ST_WRITE && mem_wr_out && mem_ack_in && !mem_fault_in
         && will_drop) |=> $stable(producer_reg)) // [RQ10]
        else $error("Producer moved on a full synchronized ring");
    drop_count_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_reg == prof_pkg::ST_WRITE && mem_wr_out && mem_ack_in && !mem_fault_in && full)
        |=> dropped_reg == $past(dropped_reg) + prof_pkg::ONE_64) // [RQ9] [RQ10]
        else $error("Dropped count not bumped");
    user_type_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (mem_is_record_out && mem_wr_out) |-> mem_record_out.record_type_code ==
        (req_reg.is_user ? prof_pkg::TYPE_USER_RECORD : prof_pkg::TYPE_VALUE_SAMPLE))
        // [RQ3] [RQ15]
        else $error("Wrong record type code");
    off_carry_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_reg == prof_pkg::ST_IDLE && req_valid_in && req_in.is_user && !enable_in
         && protected_mode_in && available_in) |=> carry_valid_out && !carry_flag_out) // [RQ18]
        else $error("Disabled user record did not clear carry");
    retire_once_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        done_out |-> retired_out) // [RQ14] [RQ20]
        else $error("Completed instruction not retired");
    sample_carry_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (done_out && !req_reg.is_user) |-> !carry_valid_out) // [RQ13]
        else $error("Value sample touched carry");
endmodule

// *** ring_memory_model.sv ***
// Memory model: answers operand fetches and ring writes after a programmable delay
`timescale 1ns/1ns
module ring_memory_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [3:0] delay_in,
    input wire logic fault_in,
    input wire logic operand_fetch_in,
    input wire logic mem_wr_in,
    output logic operand_ready_out,
    output logic mem_ack_out,
    output logic mem_fault_out
);
    logic [3:0] fetch_cnt_reg;
    logic [3:0] write_cnt_reg;
    ////////////////////////////////////////////////////////////////////////////////
    // Operand answer is a one-cycle pulse; a held request is served again after each delay
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fetch_cnt_reg <= 4'h0;
            operand_ready_out <= 1'b0;
        end else if (operand_ready_out || !operand_fetch_in) begin
            fetch_cnt_reg <= 4'h0;
            operand_ready_out <= 1'b0;
        end else if (fetch_cnt_reg == delay_in) begin
            operand_ready_out <= 1'b1;
        end else begin
            fetch_cnt_reg <= fetch_cnt_reg + 4'h1;
        end
    end
    // An unmapped block answers with a fault beside the acknowledge
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            write_cnt_reg <= 4'h0;
            mem_ack_out <= 1'b0;
            mem_fault_out <= 1'b0;
        end else if (mem_ack_out || mem_fault_out || !mem_wr_in) begin
            write_cnt_reg <= 4'h0;
            mem_ack_out <= 1'b0;
            mem_fault_out <= 1'b0;
        end else if (write_cnt_reg == delay_in) begin
            mem_ack_out <= 1'b1;
            mem_fault_out <= fault_in;
        end else begin
            write_cnt_reg <= write_cnt_reg + 4'h1;
        end
    end
endmodule

// *** profiling_record_inserter_tb.sv ***
// Testbench: issues profiling instructions and checks records, offsets and flags
`timescale 1ns/1ns
module profiling_record_inserter_tb;
    logic clk_in, rst_n_in, enable_in, available_in, protected_mode_in, continuous_mode_in;
    logic req_valid_in, operand_ready_in, mem_ack_in, mem_fault_in, fault_in;
    logic [31:0] cb_flags_in, buffer_size_in, threshold_in, first_event_period_in;
    logic [31:0] ring_consumer_offset_in, ring_producer_offset_out;
    logic [63:0] buffer_base_in, dropped_event_count_out, d0;
    logic [63:0] mem_addr_out, mem_field_out, rec_addr, fld_addr, fld_val;
    logic [3:0] random_bits_in, delay_in;
    prof_pkg::insert_req_t req_in;
    prof_pkg::event_record_t mem_record_out, rec;
    logic operand_fetch_out, mem_wr_out, mem_is_record_out, done_out, invalid_opcode_fault_out;
    logic access_fault_out, carry_flag_out, carry_valid_out, retired_out, threshold_int_out;
    logic [7:0] obs;
    int bad_count = 0;
    int n_compared = 0;
    ////////////////////////////////////////////////////////////////////////////////
    profiling_record_inserter profiling_record_inserter_i (.clk_in, .rst_n_in, .enable_in,
        .available_in, .protected_mode_in, .continuous_mode_in, .cb_flags_in, .buffer_size_in,
        .buffer_base_in, .threshold_in, .first_event_period_in, .random_bits_in,
        .ring_consumer_offset_in, .req_valid_in, .req_in, .operand_ready_in, .mem_ack_in,
        .mem_fault_in, .operand_fetch_out, .mem_wr_out, .mem_addr_out, .mem_record_out,
        .mem_is_record_out, .mem_field_out, .done_out, .invalid_opcode_fault_out,
        .access_fault_out, .carry_flag_out, .carry_valid_out, .retired_out, .threshold_int_out,
        .ring_producer_offset_out, .dropped_event_count_out);
    ring_memory_model ring_memory_model_i (.clk_in, .rst_n_in, .delay_in, .fault_in,
        .operand_fetch_in(operand_fetch_out), .mem_wr_in(mem_wr_out),
        .operand_ready_out(operand_ready_in), .mem_ack_out(mem_ack_in),
        .mem_fault_out(mem_fault_in));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock, 10 ns period
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // Sampled mid-cycle so one-cycle pulses are never missed
    always @(negedge clk_in) begin
        obs |= {invalid_opcode_fault_out, access_fault_out, operand_fetch_out, 1'b0,
            retired_out, carry_valid_out, carry_valid_out & carry_flag_out, threshold_int_out};
        if ((mem_wr_out & mem_ack_in & mem_is_record_out) === 1'b1) begin
            obs[4] = 1'b1;
            rec = mem_record_out;
            rec_addr = mem_addr_out;
        end else if ((mem_wr_out & mem_ack_in) === 1'b1) begin
            fld_addr = mem_addr_out;
            fld_val = mem_field_out;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [191:0] seen, input logic [191:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        if (bad_count == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Re-enable latches the session fields, so they change only while disabled
    task automatic start(input logic [31:0] flags, input logic cont, input logic [31:0] cons);
        enable_in <= 1'b0;
        cb_flags_in <= flags;
        continuous_mode_in <= cont;
        ring_consumer_offset_in <= cons;
        repeat (2) @(posedge clk_in);
        enable_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        d0 = dropped_event_count_out;
    endtask
    // Observation bits: fault, access fault, fetch, record, retired, carry valid, carry, irq
    task automatic run_op(input logic user, input logic s32, input logic [7:0] exp,
        input logic [7:0] mask);
        int i;
        obs = 8'h00;
        req_in <= '{is_user: user, size_is_32: s32, extra_reg: 64'hFEDCBA9876543210,
            operand: 32'hCAFEF00D, immediate: 32'hABCD1234, ip: 64'h0000000000004000};
        req_valid_in <= 1'b1;
        @(posedge clk_in);
        req_valid_in <= 1'b0;
        for (i = 0; i < 300; i++) begin
            @(negedge clk_in);
            if ((done_out | invalid_opcode_fault_out | access_fault_out) === 1'b1) break;
        end
        if (i == 300) begin
            bad_count++;
            test_done();
        end
        repeat (2) @(posedge clk_in);
        check(obs & mask, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n_in, enable_in, continuous_mode_in, req_valid_in, fault_in} = 5'h00;
        {available_in, protected_mode_in} = 2'h3;
        {cb_flags_in, ring_consumer_offset_in, req_in} = '0;
        buffer_size_in = 32'h00000080;
        buffer_base_in = 64'h0000000000001000;
        threshold_in = 32'h00000040;
        first_event_period_in = 32'h00000001;
        random_bits_in = 4'h0;
        delay_in = 4'h0;
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        start(32'h80000002, 1'b0, 32'h00000000); // Reserved flag bits kept zero
        run_op(1'b0, 1'b1, 8'h08, 8'hFF);
        check(ring_producer_offset_out, 32'h00000000);
        delay_in <= 4'h3;
        run_op(1'b0, 1'b1, 8'h38, 8'hFF);
        check(rec, {64'h0000000076543210, 64'h4000, 32'hCAFEF00D, 32'h123400_01});
        check(ring_producer_offset_out, 32'h00000020);
        check({rec_addr, fld_addr, fld_val}, {64'h1000, 64'hF98, 64'h0});
        run_op(1'b0, 1'b1, 8'h08, 8'hFF);
        run_op(1'b1, 1'b0, 8'h3C, 8'hFF);
        run_op(1'b1, 1'b0, 8'h3D, 8'hFF);
        check(ring_producer_offset_out, 32'h00000060);
        delay_in <= 4'h0;
        run_op(1'b1, 1'b0, 8'h3E, 8'hFE);
        check(rec, {64'hFEDCBA9876543210, 64'h4000, 32'hCAFEF00D, 32'h123400_FF});
        check({ring_producer_offset_out, dropped_event_count_out - d0}, {32'h60, 64'h1});
        check({rec_addr, fld_val}, {64'h1060, 64'h1});
        fault_in <= 1'b1;
        run_op(1'b1, 1'b0, 8'h40, 8'hC0);
        fault_in <= 1'b0;
        enable_in <= 1'b0;
        run_op(1'b1, 1'b0, 8'h04, 8'hF7);
        run_op(1'b0, 1'b0, 8'h00, 8'hF7);
        protected_mode_in <= 1'b0;
        run_op(1'b1, 1'b0, 8'h80, 8'hF0);
        run_op(1'b0, 1'b0, 8'h80, 8'hF0);
        protected_mode_in <= 1'b1;
        available_in <= 1'b0;
        run_op(1'b0, 1'b0, 8'h80, 8'hF0);
        available_in <= 1'b1;
        start(32'h00000000, 1'b1, 32'h00000020);
        run_op(1'b0, 1'b0, 8'h00, 8'hF7);
        run_op(1'b1, 1'b0, 8'h3C, 8'hFF);
        check({ring_producer_offset_out, dropped_event_count_out - d0}, {32'h20, 64'h1});
        test_done();
    end
endmodule
